// ---- design/urct_cfg.svh ----
// Register map, field positions and reset values of the reload/capture timers
`ifndef URCT_CFG_SVH
`define URCT_CFG_SVH
// Register word offsets (byte address = offset, one aligned word each)
`define URCT_SPAN        8'h20
`define URCT_OFF_LOW     8'h00
`define URCT_OFF_HIGH    8'h04
`define URCT_OFF_RLOW    8'h08
`define URCT_OFF_RHIGH   8'h0c
`define URCT_OFF_CTRL    8'h10
`define URCT_OFF_CFG     8'h14
// Control register fields
`define URCT_CN_WRAP     7
`define URCT_CN_EXTF     6
`define URCT_CN_EXTEN    3
`define URCT_CN_RUN      2
`define URCT_CN_CNTSEL   1
`define URCT_CN_CAPSEL   0
// Configuration register fields
`define URCT_CF_CSHI     4
`define URCT_CF_CSLO     3
`define URCT_CF_TOG      2
`define URCT_CF_OE       1
`define URCT_CF_DECREMENT_ENABLE     0
// Masks of writable bits and reset values
`define URCT_CN_MASK     8'hcf
`define URCT_CF_MASK     8'h1f
`define URCT_RST_BYTE    8'h00
// Divider and wrap constants
`define URCT_DIV2        4'h1
`define URCT_DIV12       4'hb
`define URCT_EXTDIV8     3'h7
`define URCT_TOP         16'hffff
`define URCT_ZERO        16'h0000
`endif

// ---- design/urct_pkg.sv ----
// Types shared by the reload/capture timer block
package urct_pkg;
  // Clock select encoding
  typedef enum logic [1:0] {
    URCT_CLK_SYS   = 2'h0,
    URCT_CLK_DIV2  = 2'h1,
    URCT_CLK_DIV12 = 2'h2,
    URCT_CLK_EXT8  = 2'h3
  } urct_clksel_t;

  // Per-timer software-visible and internal state
  typedef struct packed {
    logic [15:0] count;    // Running count
    logic [15:0] reload;   // Reload / capture pair
    logic [7:0]  ctrl;     // Control register
    logic [7:0]  cfg;      // Configuration register
    logic        cntSync1; // Count pin sync stage 1
    logic        cntSync2; // Count pin sync stage 2
    logic        cntLast;  // Previous synced count pin
    logic        trgSync1; // Trigger pin sync stage 1
    logic        trgSync2; // Trigger pin sync stage 2
    logic        trgLast;  // Previous synced trigger pin
  } urct_tmr_t;

  // Avalon answer group
  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } urct_ans_t;
endpackage : urct_pkg

// ---- design/urct_timer.sv ----
// Three 16-bit up/down reload/capture timers behind an Avalon-MM slave
`include "urct_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Block overview
//
// Register map
// Each timer owns a span of 0x20 bytes; bits 7:5 of the byte address pick
// the timer and bits 4:0 pick the register inside its span.
// Every register is one byte wide and sits in bits 7:0 of the data word.
// Bits 31:8 of read data are always zero.
// Offsets that are not mapped read as zero and ignore writes.
// A timer index of three or more also reads as zero and ignores writes.
//
// Bus timing
// Every access costs exactly one wait state, reads and writes alike.
// In the first cycle waitrequest is high and read data is prepared.
// In the second cycle waitrequest is low and read data stands.
// A write lands only at the edge where waitrequest is seen low, so a
// master that drops its request early never half-writes a register.
// Read data is registered, which costs the wait state but keeps the
// wide read multiplexer out of the slave's output path.
// Writes need byte lane 0 enabled; other lanes are ignored.
//
// Count and reload pair
// The count and reload values are two byte registers each.
// There is no shadow latch: a read of the low byte followed by a read
// of the high byte may straddle a carry while the timer runs.
// Software that needs a coherent value stops the timer first, or reads
// high, low, high and retries on a change.
//
// Clock sources
// The /2 and /12 enables come from one shared free-running prescaler.
// The first tick after start therefore has an arbitrary phase, which
// can cost up to one prescaled period of accuracy on short intervals.
// The oscillator is sampled by two flip-flops and its rising edges are
// divided by eight. It must run slower than half the system clock, or
// edges are lost without any warning.
//
// Pins
// Count and trigger pins pass two flip-flops before any logic reads
// them, so a pin edge shows in the count three clocks later.
// Pulses on them must last at least two clocks high and two low.
// While decrement is enabled the trigger pin only sets direction.
//
// Flags
// The wrap flag and the capture flag stay set until software writes a
// zero. A hardware set in the same cycle as such a write wins only if the
// flag was clear before; a repeat event on a set flag is lost to the clear.
// In reload function the external flag is the 17th count bit and
// toggles on every wrap; it raises no request there.
//
// Toggle output
// The toggle level flips on every wrap whether or not the output is
// enabled; the enable only gates the pad driver. Writing the toggle
// bit forces the level, which lets software start the wave in a known
// state or park the pin while the timer is halted.
//
// Reset
// Reset is synchronous and clears every register of the block,
// including the synchronisers, so pins seen low at release do not
// produce an edge until they have been high for a while.
//
// Interrupt request
// There is no enable inside the block; timerIrq is the raw request.
// It follows the wrap flag, and in capture function the capture flag.
////////////////////////////////////////////////////////////////////////////

module urct_timer #(
  parameter int NTMR = 3  // Number of timer instances
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              extClk,
  input  wire logic [NTMR-1:0]   extCountIn,
  input  wire logic [NTMR-1:0]   extTriggerDirIn,
  output logic [NTMR-1:0]        toggleOut,
  output logic [NTMR-1:0]        toggleOe,
  output logic [NTMR-1:0]        timerIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Whole state of the block in one struct
  typedef struct packed {
    urct_pkg::urct_tmr_t [NTMR-1:0] tmr;  // Timer instances
    logic [3:0]  preDiv;       // System clock prescaler
    logic        extSync1;     // External oscillator sync stage 1
    logic        extSync2;     // External oscillator sync stage 2
    logic        extLast;      // Previous synced oscillator level
    logic [2:0]  extDiv;       // Oscillator rising-edge counter
    logic        ackDone;      // Access answered this cycle
    logic [31:0] rdData;       // Registered read data
  } urct_state_t;

  urct_state_t st;       // Current state
  urct_state_t next_st;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Timer index from address bits 7:5; values of NTMR or more match no timer
  function automatic int unsigned tmrIndex(input logic [7:0] addr);
    tmrIndex = int'(addr[7:5]);
  endfunction : tmrIndex

  // Register offset inside one timer's span
  function automatic logic [7:0] regOffset(input logic [7:0] addr);
    regOffset = {3'h0, addr[4:0]};
  endfunction : regOffset

  // Tick enable for the chosen clock source
  function automatic logic pickTick(input logic [1:0] sel,
                                    input logic tDiv2,
                                    input logic tDiv12,
                                    input logic tExt8);
    case (urct_pkg::urct_clksel_t'(sel))
      urct_pkg::URCT_CLK_SYS:   pickTick = 1'b1;
      urct_pkg::URCT_CLK_DIV2:  pickTick = tDiv2;
      urct_pkg::URCT_CLK_DIV12: pickTick = tDiv12;
      urct_pkg::URCT_CLK_EXT8:  pickTick = tExt8;
      default:                  pickTick = 1'b0;
    endcase
  endfunction : pickTick

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescale enables, derived from current state
  logic tickDiv2;   // System clock / 2 enable
  logic tickDiv12;  // System clock / 12 enable
  logic tickExt8;   // External clock / 8 enable
  logic accValid;   // Bus access in progress and not yet answered

  // Oscillator edges seen at 20 MHz; the oscillator must be slower than
  // half the system clock or edges are lost
  always_comb begin
    tickDiv2  = st.preDiv[0];
    tickDiv12 = (st.preDiv == `URCT_DIV12);
    tickExt8  = st.extSync2 && !st.extLast &&
                (st.extDiv == `URCT_EXTDIV8);
    accValid  = (read || write) && !st.ackDone;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic        tick;      // Count event for this timer
    logic        up;        // Counting direction
    logic        trgFall;   // Trigger falling edge
    logic        cntFall;   // Count pin falling edge
    logic        wrap;      // Overflow or underflow
    logic        capMode;   // Capture function selected
    logic        decrement_enable;      // Decrement enable
    logic [15:0] cnt;       // Working count
    logic [7:0]  wb;        // Written byte
    logic        hitLow;    // Bus write hits the low byte lane
    int unsigned idx;       // Addressed timer
    logic [7:0]  off;       // Addressed register

    tick    = 1'b0;
    up      = 1'b1;
    trgFall = 1'b0;
    cntFall = 1'b0;
    wrap    = 1'b0;
    capMode = 1'b0;
    decrement_enable    = 1'b0;
    cnt     = `URCT_ZERO;
    wb      = writedata[7:0];
    hitLow  = byteenable[0];
    idx     = tmrIndex(address);
    off     = regOffset(address);
    next_st = st;

    // Prescalers run free
    next_st.preDiv = (st.preDiv == `URCT_DIV12) ? 4'h0 : st.preDiv + 4'h1;
    next_st.extSync1 = extClk;
    next_st.extSync2 = st.extSync1;
    next_st.extLast  = st.extSync2;
    if (st.extSync2 && !st.extLast) begin
      next_st.extDiv = st.extDiv + 3'h1;
    end

    // Bus answer: one wait cycle, then ack
    next_st.ackDone = accValid;
    next_st.rdData  = 32'h0;

    for (int i = 0; i < NTMR; i++) begin
      // Pin synchronisers and edge detectors
      next_st.tmr[i].cntSync1 = extCountIn[i];
      next_st.tmr[i].cntSync2 = st.tmr[i].cntSync1;
      next_st.tmr[i].cntLast  = st.tmr[i].cntSync2;
      next_st.tmr[i].trgSync1 = extTriggerDirIn[i];
      next_st.tmr[i].trgSync2 = st.tmr[i].trgSync1;
      next_st.tmr[i].trgLast  = st.tmr[i].trgSync2;
      cntFall = st.tmr[i].cntLast && !st.tmr[i].cntSync2;
      trgFall = st.tmr[i].trgLast && !st.tmr[i].trgSync2;

      capMode = st.tmr[i].ctrl[`URCT_CN_CAPSEL];
      decrement_enable    = st.tmr[i].cfg[`URCT_CF_DECREMENT_ENABLE];
      up      = decrement_enable ? st.tmr[i].trgSync2 : 1'b1;
      // Direction pin edges are masked out while decrementing
      if (decrement_enable) begin
        trgFall = 1'b0;
      end
      if (!st.tmr[i].ctrl[`URCT_CN_EXTEN]) begin
        trgFall = 1'b0;
      end

      if (st.tmr[i].ctrl[`URCT_CN_CNTSEL]) begin
        tick = cntFall;
      end else begin
        tick = pickTick({st.tmr[i].cfg[`URCT_CF_CSHI],
                         st.tmr[i].cfg[`URCT_CF_CSLO]},
                        tickDiv2, tickDiv12, tickExt8);
      end
      // Run bit gates counting in both functions
      tick = tick && st.tmr[i].ctrl[`URCT_CN_RUN];

      cnt  = st.tmr[i].count;
      wrap = 1'b0;
      if (tick) begin
        if (up) begin
          wrap = (cnt == `URCT_TOP);
          cnt  = cnt + 16'h1;
          if (wrap && !capMode) begin
            cnt = st.tmr[i].reload;
          end
        end else if (capMode) begin
          wrap = (cnt == `URCT_ZERO);
          cnt  = cnt - 16'h1;
        end else begin
          wrap = (cnt == st.tmr[i].reload);
          cnt  = wrap ? `URCT_TOP : cnt - 16'h1;
        end
      end

      if (capMode) begin
        // Capture function: only live while running
        if (trgFall && st.tmr[i].ctrl[`URCT_CN_RUN]) begin
          next_st.tmr[i].reload = st.tmr[i].count;
          next_st.tmr[i].ctrl[`URCT_CN_EXTF] = 1'b1;
        end
      end else begin
        // Reload function: trigger edge reloads immediately
        if (trgFall && st.tmr[i].ctrl[`URCT_CN_RUN]) begin
          cnt  = st.tmr[i].reload;
        end
        if (wrap) begin
          next_st.tmr[i].ctrl[`URCT_CN_EXTF] =
            !st.tmr[i].ctrl[`URCT_CN_EXTF];
        end
      end
      if (wrap) begin
        next_st.tmr[i].ctrl[`URCT_CN_WRAP] = 1'b1;
        // Output inverts once per wrap: half period per reload span
        next_st.tmr[i].cfg[`URCT_CF_TOG] =
          !st.tmr[i].cfg[`URCT_CF_TOG];
      end
      next_st.tmr[i].count = cnt;

      // Register access to this timer
      if (idx == i) begin
        // Writes land at the edge where waitrequest is seen low
        if (write && hitLow && st.ackDone) begin
          case (off)
            `URCT_OFF_LOW:   next_st.tmr[i].count[7:0]   = wb;
            `URCT_OFF_HIGH:  next_st.tmr[i].count[15:8]  = wb;
            `URCT_OFF_RLOW:  next_st.tmr[i].reload[7:0]  = wb;
            `URCT_OFF_RHIGH: next_st.tmr[i].reload[15:8] = wb;
            `URCT_OFF_CTRL: begin
              // Flags: software may clear; a same-cycle set wins only if the flag was clear
              next_st.tmr[i].ctrl = (wb & `URCT_CN_MASK) |
                (next_st.tmr[i].ctrl & st.tmr[i].ctrl & 8'hc0 &
                 ~st.tmr[i].ctrl) |
                (next_st.tmr[i].ctrl & ~st.tmr[i].ctrl & 8'hc0);
              if (!capMode) begin
                // Toggle of the 17th bit is hardware-owned but writable
                next_st.tmr[i].ctrl[`URCT_CN_EXTF] =
                  wrap ? next_st.tmr[i].ctrl[`URCT_CN_EXTF] |
                         wb[`URCT_CN_EXTF]
                       : wb[`URCT_CN_EXTF];
              end
            end
            `URCT_OFF_CFG: begin
              next_st.tmr[i].cfg = wb & `URCT_CF_MASK;
            end
            default: ;
          endcase
        end
        // Read data is prepared in the wait cycle
        if (read && accValid) begin
          case (off)
            `URCT_OFF_LOW:   next_st.rdData = {24'h0, st.tmr[i].count[7:0]};
            `URCT_OFF_HIGH:  next_st.rdData = {24'h0, st.tmr[i].count[15:8]};
            `URCT_OFF_RLOW:  next_st.rdData = {24'h0, st.tmr[i].reload[7:0]};
            `URCT_OFF_RHIGH: next_st.rdData = {24'h0, st.tmr[i].reload[15:8]};
            `URCT_OFF_CTRL:  next_st.rdData = {24'h0, st.tmr[i].ctrl};
            `URCT_OFF_CFG:   next_st.rdData = {24'h0, st.tmr[i].cfg};
            default:         next_st.rdData = 32'h0;
          endcase
        end
      end
    end

    // Synchronous reset
    if (!rst_n) begin
      next_st = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    readdata    = st.rdData;
    waitrequest = (read || write) && !st.ackDone;
    for (int i = 0; i < NTMR; i++) begin
      toggleOut[i] = st.tmr[i].cfg[`URCT_CF_TOG];
      // Output enabled only in reload timer function
      toggleOe[i]  = st.tmr[i].cfg[`URCT_CF_OE] &&
                     !st.tmr[i].ctrl[`URCT_CN_CAPSEL] &&
                     !st.tmr[i].ctrl[`URCT_CN_CNTSEL];
      // Both flags request in capture; wrap only in reload
      timerIrq[i]  = st.tmr[i].ctrl[`URCT_CN_WRAP] ||
                     (st.tmr[i].ctrl[`URCT_CN_CAPSEL] &&
                      st.tmr[i].ctrl[`URCT_CN_EXTF]);
    end
  end

endmodule : urct_timer

// ---- tb/updown_reload_capture_timer_test.sv ----
// Self-checking bench of the reload/capture timer block
module updown_reload_capture_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;    // 20 MHz system clock
  logic        rst_n = 1'b0;  // Synchronous reset
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'h1;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        extClk;
  logic [2:0]  extCountIn, extTriggerDirIn, toggleOut, toggleOe, timerIrq;
  int          miscompares = 0;
  int          compares = 0;

  always #25 clk = ~clk;

  urct_timer #(.NTMR(3)) uut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .extClk(extClk),
    .extCountIn(extCountIn), .extTriggerDirIn(extTriggerDirIn),
    .toggleOut(toggleOut), .toggleOe(toggleOe), .timerIrq(timerIrq));
  urct_pin_model #(.NTMR(3)) pins (.clk(clk), .extClk(extClk),
    .extCountIn(extCountIn), .extTriggerDirIn(extTriggerDirIn));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // One Avalon access; waitrequest and data are taken at rising edges
  task automatic bus(input logic wr, input logic [7:0] a, d,
                     output logic [7:0] q);
    logic w;
    int   n;
    w = 1'b1;
    n = 0;
    read      <= ~wr;
    write     <= wr;
    address   <= a;
    writedata <= {24'h0, d};
    while (w !== 1'b0 && n < 50) begin
      @(posedge clk);
      w = waitrequest;
      q = readdata[7:0];
      n++;
    end
    read  <= 1'b0;
    write <= 1'b0;
    check("answer", 16'h0, {15'h0, w});
    @(posedge clk);  // Keeps strobes from being set twice in one step
  endtask : bus

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, m, e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(nm, {8'h0, e}, {8'h0, q & m});
  endtask : rdc

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int r = 0; r < 6; r++) begin
      rdc("reset reg", 8'(r * 4), 8'hff, 8'h00);
    end
    rdc("gap", 8'h18, 8'hff, 8'h00);
    rdc("timer 3", 8'h60, 8'hff, 8'h00);
    wr(8'h00, 8'h5a);
    wr(8'h04, 8'ha5);
    rdc("low byte", 8'h00, 8'hff, 8'h5a);
    rdc("high byte", 8'h04, 8'hff, 8'ha5);
    byteenable <= 4'h0;
    wr(8'h00, 8'h33);
    byteenable <= 4'h1;
    rdc("lane off", 8'h00, 8'hff, 8'h5a);
  endtask : t_reset

  // Reload 0xfffe toggles the output every second system clock
  task automatic t_reload_up;
    logic t;
    int   n;
    wr(8'h08, 8'hfe);
    wr(8'h0c, 8'hff);
    wr(8'h00, 8'hfd);
    wr(8'h04, 8'hff);
    wr(8'h14, 8'h02);
    wr(8'h10, 8'h04);
    @(negedge clk);
    t = toggleOut[0];
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (toggleOut[0] === t && n < 99) begin
        @(negedge clk);
        n++;
      end
      t = toggleOut[0];
    end
    @(posedge clk);
    check("half period", 16'h2, 16'(n));
    check("oe", 16'h1, {15'h0, toggleOe[0]});
    check("wrap irq", 16'h1, {15'h0, timerIrq[0]});
    wr(8'h10, 8'h80);
    rdc("reloaded hi", 8'h04, 8'hff, 8'hff);
    rdc("reloaded lo", 8'h00, 8'hfe, 8'hfe);
    wr(8'h14, 8'h06);
    check("forced high", 16'h1, {15'h0, toggleOut[0]});
    rdc("toggle bit", 8'h14, 8'h04, 8'h04);
    wr(8'h14, 8'h00);
    check("forced low", 16'h0, {15'h0, toggleOut[0]});
    check("oe off", 16'h0, {15'h0, toggleOe[0]});
    wr(8'h10, 8'h00);
    check("cleared", 16'h0, {15'h0, timerIrq[0]});
  endtask : t_reload_up

  // Down count from 3 reaches reload 1 and restarts at 0xffff
  task automatic t_down;
    pins.set_dir(0, 1'b0);
    wr(8'h08, 8'h01);
    wr(8'h0c, 8'h00);
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h10, 8'h04);
    repeat (6) @(posedge clk);
    check("under irq", 16'h1, {15'h0, timerIrq[0]});
    wr(8'h10, 8'h00);
    rdc("under hi", 8'h04, 8'hff, 8'hff);
  endtask : t_down

  // Each clock select runs about 99 clocks; prescaler phase is free
  task automatic t_clocks;
    int         exp [4] = '{99, 49, 8, 3};
    logic [7:0] q;
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      wr(8'h14, 8'(s << 3));
      wr(8'h10, 8'h04);
      repeat (96) @(posedge clk);
      wr(8'h10, 8'h00);
      bus(1'b0, 8'h00, 8'h00, q);
      check("ticks", 16'h1, {15'h0, int'(q) + 2 >= exp[s] && int'(q) <= exp[s] + 2});
    end
  endtask : t_clocks

  // Timer 1 counts pin edges, then captures; disabled trigger is ignored
  task automatic t_capture;
    wr(8'h30, 8'h0f);
    repeat (3) pins.fall_count(1);
    pins.fall_trig(1);
    rdc("captured", 8'h28, 8'hff, 8'h03);
    rdc("ext flag", 8'h30, 8'h40, 8'h40);
    check("cap irq", 16'h1, {15'h0, timerIrq[1]});
    wr(8'h30, 8'h07);
    pins.fall_count(1);
    pins.fall_trig(1);
    rdc("no capture", 8'h28, 8'hff, 8'h03);
    rdc("no flag", 8'h30, 8'h40, 8'h00);
    rdc("one per edge", 8'h20, 8'hff, 8'h04);
  endtask : t_capture

  // Timer 2 in capture function wraps down through zero, then up
  task automatic t_cap_wrap;
    for (int up = 0; up < 2; up++) begin
      pins.set_dir(2, up[0]);
      wr(8'h40, up ? 8'hff : 8'h01);
      wr(8'h44, up ? 8'hff : 8'h00);
      wr(8'h54, 8'h01);
      wr(8'h50, 8'h05);
      repeat (4) @(posedge clk);
      check("wrap irq", 16'h1, {15'h0, timerIrq[2]});
      wr(8'h50, 8'h00);
      rdc("wrap hi", 8'h44, 8'hff, up ? 8'h00 : 8'hff);
    end
  endtask : t_cap_wrap

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // Tests need about 700 clocks
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_reload_up();
    t_down();
    t_clocks();
    t_capture();
    t_cap_wrap();
    complete_run();
  end
endmodule : updown_reload_capture_timer_test

// ---- tb/urct_pin_model.sv ----
// Pin-side model: oscillator, count pins and trigger/direction pins
module urct_pin_model #(
  parameter int NTMR = 3  // Timer count
) (
  input  wire logic       clk,
  output logic            extClk,
  output logic [NTMR-1:0] extCountIn,
  output logic [NTMR-1:0] extTriggerDirIn
);
  timeunit 1ns;
  timeprecision 1ns;

  // Pins idle high so the first low is a real falling edge
  initial begin
    extClk          = 1'b0;
    extCountIn      = '1;
    extTriggerDirIn = '1;
  end

  // Free-running oscillator, deliberately unrelated to clk
  always #85 extClk = ~extClk;

  // Falling edge on a count pin; three clocks each level beat the sync
  task automatic fall_count(input int i);
    extCountIn[i] <= 1'b0;
    repeat (3) @(posedge clk);
    extCountIn[i] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : fall_count

  // Falling edge on a trigger pin
  task automatic fall_trig(input int i);
    extTriggerDirIn[i] <= 1'b0;
    repeat (3) @(posedge clk);
    extTriggerDirIn[i] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : fall_trig

  // Direction level, held while decrement is enabled
  task automatic set_dir(input int i, input logic v);
    extTriggerDirIn[i] <= v;
  endtask : set_dir
endmodule : urct_pin_model

// ---- tb/urct_timer_monitor.sv ----
// Port checker of the reload/capture timer block
module urct_timer_monitor #(
  parameter int NTMR = 3  // Timer count
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic [7:0]      address,
  input wire logic            read,
  input wire logic            write,
  input wire logic [31:0]     writedata,
  input wire logic [31:0]     readdata,
  input wire logic            waitrequest,
  input wire logic [NTMR-1:0] toggleOut,
  input wire logic [NTMR-1:0] toggleOe,
  input wire logic [NTMR-1:0] timerIrq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Writes to timer 0 config, at the edge they take effect
  logic cfgWr;
  assign cfgWr = write && !waitrequest && address == 8'h14;

  ////////////////////////////////////////////////////////////////////////
  property p_one_wait;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access took more than one wait state");
  property p_upper_zero;
    read && !waitrequest |-> readdata[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data above byte not zero");
  property p_unmapped;
    read && !waitrequest && (address[4:0] > 5'h14 || address[7:5] > 3'h2)
      |-> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_oe_off;
    cfgWr && !writedata[1] |=> !toggleOe[0];
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("output enabled with enable bit clear");
  property p_tog_force;
    cfgWr |=> toggleOut[0] == $past(writedata[2]);
  endproperty
  a_tog_force: assert property (p_tog_force)
    else $error("toggle level not forced by write");
  property p_tog_read;
    read && !waitrequest && address == 8'h14 && $stable(toggleOut[0])
      |-> readdata[2] == toggleOut[0];
  endproperty
  a_tog_read: assert property (p_tog_read)
    else $error("toggle bit read differs from pin");
  // Only a write may drop a set flag
  property p_flag_hold;
    timerIrq[0] && !write |=> timerIrq[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped without software write");
  property p_reset_quiet;
    $rose(rst_n) |-> toggleOut == '0 && toggleOe == '0 && timerIrq == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
endmodule : urct_timer_monitor

bind urct_timer urct_timer_monitor #(.NTMR(NTMR)) mon (
  .clk(clk), .rst_n(rst_n), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .toggleOut(toggleOut),
  .toggleOe(toggleOe), .timerIrq(timerIrq)
);
